/* File: design/blpt_consts.vh */
// Constants for the bulk list pointer tracking block.
// Overview of operation
// - After serving the current bulk descriptor, advance the current pointer to the next.
// - Each new frame resumes bulk processing at the stored current pointer.
// - At the end of the bulk list, examine the bulk list fill flag.
// - Fill flag clear at list end: leave the bulk pointers alone.
// - Fill flag set at list end: copy the head pointer to current, clear the flag.
// - Reading the current pointer returns the live value in use.
// - The current pointer resets to zero; zero means end of list.
// - Keep a done queue head holding the last completed descriptor address.
// - Periodically write the done queue head to the shared comm area.
// - On completion, store the old head into the descriptor, then take its address.
// - After writing the head to the comm area, clear the head register to zero.
`ifndef BLPT_CONSTS_VH
`define BLPT_CONSTS_VH
`define BLPT_OFS_BULK_CUR 8'h2C
`define BLPT_OFS_DONE_HEAD 8'h30
`define BLPT_OFS_BULK_HEAD 8'h28
`define BLPT_OFS_CMD_STAT 8'h08
`define BLPT_OFS_CONTROL 8'h04
`define BLPT_OFS_WB_PERIOD 8'h40
`define BLPT_BIT_FILL 1
`define BLPT_BIT_RUN 5
`define BLPT_PTR_LSB 4
`define BLPT_WB_PERIOD_RST 16'h0100
`endif

/* File: design/blpt_ptr_reg.v */
// Aligned pointer register with synchronous load and asynchronous clear.
`timescale 1ns/1ns
`include "blpt_consts.vh"
module blpt_ptr_reg
(
  input wire clk_sys_i, // System clock.
  input wire arst_n_i, // Asynchronous reset, active low.
  input wire load_i, // Load strobe.
  input wire [31:0] data_i, // Value to load.
  output wire [31:0] ptr_o // Registered pointer.
);
  reg [27:0] ptr_ff;

  // Only the upper 28 bits are stored, so the low bits can never be nonzero.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      ptr_ff <= 28'h0000000;
    else if (load_i)
      ptr_ff <= data_i[31:`BLPT_PTR_LSB];
  end

  assign ptr_o = {ptr_ff, 4'h0};
endmodule

/* File: design/blpt_top.v */
// Bulk list pointer and done queue head tracking.
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ns
`include "blpt_consts.vh"
module blpt_top
#(
  parameter WB_PERIOD_W = 16
)
(
  input wire clk_sys_i, // System clock, 250 MHz.
  input wire arst_n_i, // Asynchronous reset, active low.
  input wire [7:0] reg_addr_i, // Register byte address.
  input wire [31:0] reg_wdata_i, // Register write data.
  input wire reg_wr_i, // Register write strobe.
  input wire reg_rd_i, // Register read strobe.
  output reg [31:0] reg_rdata_o, // Read data, one cycle after strobe.
  input wire ed_served_i, // Pulse: current bulk descriptor served.
  input wire [31:0] ed_next_i, // Next pointer of the served descriptor.
  input wire list_end_i, // Pulse: traversal found end of bulk list.
  input wire td_done_i, // Pulse: a transfer descriptor completed.
  input wire [31:0] td_addr_i, // Address of the completed descriptor.
  output reg td_link_we_o, // Pulse: write next pointer field.
  output reg [31:0] td_link_addr_o, // Descriptor whose next field is written.
  output reg [31:0] td_link_data_o, // Old done head stored in descriptor.
  output reg comm_we_o, // Pulse: write done head to comm area.
  output reg [31:0] comm_data_o, // Done head value for comm area.
  output wire [31:0] bulk_cur_o, // Live bulk current pointer.
  output wire bulk_run_o // Bulk list run bit.
);
  reg [31:0] control_ff;
  reg fill_ff;
  reg [27:0] head_ff;
  reg [27:0] done_ff;
  reg [WB_PERIOD_W-1:0] period_ff;
  reg [WB_PERIOD_W-1:0] wb_cnt_ff;
  reg cur_load;
  reg [31:0] cur_data;
  wire [31:0] cur_ptr;
  wire wb_tick;

  // Decoded write strobes, one per register.
  wire wr_cur;
  wire wr_cmd;
  wire wr_ctl;
  wire wr_head;
  wire wr_done;
  wire wr_period;

  // Address match used by both the write and read decoders.
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign bulk_run_o = control_ff[`BLPT_BIT_RUN];
  assign bulk_cur_o = cur_ptr;
  assign wb_tick = (wb_cnt_ff == {WB_PERIOD_W{1'b0}});

  // Write decode; each register process below then reads a single strobe.
  assign wr_cur = reg_wr_i && hit(reg_addr_i, `BLPT_OFS_BULK_CUR);
  assign wr_cmd = reg_wr_i && hit(reg_addr_i, `BLPT_OFS_CMD_STAT);
  assign wr_ctl = reg_wr_i && hit(reg_addr_i, `BLPT_OFS_CONTROL);
  assign wr_head = reg_wr_i && hit(reg_addr_i, `BLPT_OFS_BULK_HEAD);
  assign wr_done = reg_wr_i && hit(reg_addr_i, `BLPT_OFS_DONE_HEAD);
  assign wr_period = reg_wr_i && hit(reg_addr_i, `BLPT_OFS_WB_PERIOD);

  // Current pointer source; the pointer persists across frames, never reset per frame.
  always @*
  begin
    cur_load = 1'b0;
    cur_data = cur_ptr;
    if (wr_cur && !bulk_run_o)
    begin
      cur_load = 1'b1;
      cur_data = reg_wdata_i;
    end
    // A list end with the fill flag clear falls through; only a serve in the same cycle then moves the pointer.
    else if (list_end_i && fill_ff)
    begin
      cur_load = 1'b1;
      cur_data = {head_ff, 4'h0};
    end
    else if (ed_served_i)
    begin
      cur_load = 1'b1;
      cur_data = ed_next_i;
    end
  end

  blpt_ptr_reg u_cur
  (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .load_i(cur_load),
    .data_i(cur_data),
    .ptr_o(cur_ptr)
  );

  // Control register. Only the run bit is used here; the other bits are plain
  // storage so that software reads back what it wrote.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      control_ff <= 32'h00000000;
    else if (wr_ctl)
      control_ff <= reg_wdata_i;
  end

  // Fill flag: software sets it and a list end clears it. A set in the cycle of the
  // clear wins, so work that software has just announced is never dropped.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      fill_ff <= 1'b0;
    else if (wr_cmd && reg_wdata_i[`BLPT_BIT_FILL])
      fill_ff <= 1'b1;
    else if (list_end_i && fill_ff)
      fill_ff <= 1'b0;
  end

  // Bulk head pointer; only the aligned part is kept.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      head_ff <= 28'h0000000;
    else if (wr_head)
      head_ff <= reg_wdata_i[31:`BLPT_PTR_LSB];
  end

  // Write-back period. A new value only takes effect at the next tick. The divider resets
  // to zero, so the first write-back comes in the first cycle after reset.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      period_ff <= `BLPT_WB_PERIOD_RST;
    else if (wr_period)
      period_ff <= reg_wdata_i[WB_PERIOD_W-1:0];
  end

  // Write-back divider: one tick every period plus one cycles.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      wb_cnt_ff <= {WB_PERIOD_W{1'b0}};
    else
      wb_cnt_ff <= wb_tick ? period_ff : wb_cnt_ff - 1'b1;
  end

  // Comm area write of the head as it stood at the tick.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      comm_we_o <= 1'b0;
      comm_data_o <= 32'h00000000;
    end
    else
    begin
      comm_we_o <= wb_tick;
      if (wb_tick)
        comm_data_o <= {done_ff, 4'h0};
    end
  end

  // Link write into the completed descriptor. In the tick cycle the old head is
  // leaving for the comm area, so the descriptor gets zero and ends the new queue.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      td_link_we_o <= 1'b0;
      td_link_addr_o <= 32'h00000000;
      td_link_data_o <= 32'h00000000;
    end
    else
    begin
      td_link_we_o <= td_done_i;
      if (td_done_i)
      begin
        td_link_addr_o <= {td_addr_i[31:`BLPT_PTR_LSB], 4'h0};
        td_link_data_o <= wb_tick ? 32'h00000000 : {done_ff, 4'h0};
      end
    end
  end

  // Done queue head; a completion in the tick cycle wins and starts the new queue.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      done_ff <= 28'h0000000;
    else if (td_done_i)
      done_ff <= td_addr_i[31:`BLPT_PTR_LSB];
    else if (wb_tick)
      done_ff <= 28'h0000000;
    else if (wr_done)
      done_ff <= reg_wdata_i[31:`BLPT_PTR_LSB];
  end

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      reg_rdata_o <= 32'h00000000;
    else if (reg_rd_i)
    begin
      if (hit(reg_addr_i, `BLPT_OFS_BULK_CUR))
        reg_rdata_o <= cur_ptr;
      else if (hit(reg_addr_i, `BLPT_OFS_DONE_HEAD))
        reg_rdata_o <= {done_ff, 4'h0};
      else if (hit(reg_addr_i, `BLPT_OFS_BULK_HEAD))
        reg_rdata_o <= {head_ff, 4'h0};
      else if (hit(reg_addr_i, `BLPT_OFS_CMD_STAT))
        reg_rdata_o <= {30'h00000000, fill_ff, 1'b0};
      else if (hit(reg_addr_i, `BLPT_OFS_CONTROL))
        reg_rdata_o <= control_ff;
      else if (hit(reg_addr_i, `BLPT_OFS_WB_PERIOD))
        reg_rdata_o <= {{(32-WB_PERIOD_W){1'b0}}, period_ff};
      else
        reg_rdata_o <= 32'h00000000;
    end
  end
endmodule

/* File: tb/blpt_properties.sv */
// Checker of the bulk pointer and done head port relations.
`timescale 1ns/1ns
`include "blpt_consts.vh"
module blpt_properties
(
  input wire clk_sys_i, // Clock.
  input wire arst_n_i, // Reset.
  input wire [7:0] reg_addr_i, // Address.
  input wire [31:0] reg_wdata_i, // Write data.
  input wire reg_wr_i, // Write strobe.
  input wire reg_rd_i, // Read strobe.
  input wire [31:0] reg_rdata_o, // Read data.
  input wire ed_served_i, // Served.
  input wire [31:0] ed_next_i, // Next pointer.
  input wire list_end_i, // List end.
  input wire td_done_i, // Completion.
  input wire [31:0] td_addr_i, // Completed address.
  input wire td_link_we_o, // Link write.
  input wire [31:0] td_link_addr_o, // Link address.
  input wire comm_we_o, // Comm write.
  input wire [31:0] comm_data_o, // Comm data.
  input wire [31:0] bulk_cur_o, // Current pointer.
  input wire bulk_run_o // Run bit.
);
  // Helper terms, so each property reads as one cause and one effect.
  wire cur_wr = reg_wr_i && reg_addr_i == `BLPT_OFS_BULK_CUR;
  wire quiet = !td_done_i && !reg_wr_i;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  a_serve_advance: assert property (ed_served_i && !list_end_i && !cur_wr
    |=> bulk_cur_o == ($past(ed_next_i) & 32'hFFFFFFF0)) else $error("no advance");
  a_idle_hold: assert property (!ed_served_i && !list_end_i && !cur_wr
    |=> $stable(bulk_cur_o)) else $error("pointer moved");
  a_run_gate: assert property (cur_wr && bulk_run_o && !ed_served_i && !list_end_i
    |=> $stable(bulk_cur_o)) else $error("write not refused");
  a_sw_write: assert property (cur_wr && !bulk_run_o
    |=> bulk_cur_o == ($past(reg_wdata_i) & 32'hFFFFFFF0)) else $error("write lost");
  a_live_read: assert property (reg_rd_i && reg_addr_i == `BLPT_OFS_BULK_CUR
    |=> reg_rdata_o == $past(bulk_cur_o)) else $error("stale read");
  a_low_zero: assert property (bulk_cur_o[3:0] == 4'h0)
    else $error("low bits set");
  a_td_link: assert property (td_done_i
    |=> td_link_we_o && td_link_addr_o == ($past(td_addr_i) & 32'hFFFFFFF0))
    else $error("no link");
  a_comm_gap: assert property (comm_we_o |=> !comm_we_o [*4])
    else $error("comm too soon");
  a_comm_clear: assert property (quiet ##1 comm_we_o && quiet
    ##1 (quiet && !comm_we_o) [*4] ##1 comm_we_o |-> comm_data_o == 32'h0)
    else $error("head not cleared");
endmodule
bind blpt_top blpt_properties blpt_properties_inst (.clk_sys_i, .arst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ed_served_i, .ed_next_i, .list_end_i,
  .td_done_i, .td_addr_i, .td_link_we_o, .td_link_addr_o, .comm_we_o, .comm_data_o,
  .bulk_cur_o, .bulk_run_o);

/* File: tb/blpt_mem_model.sv */
// Descriptor list model in system memory.
`timescale 1ns/1ns
module blpt_mem_model
(
  input wire [31:0] cur_i, // Descriptor being served.
  output wire [31:0] next_o // Its next pointer field.
);
  // Contiguous list: each link is the next 16-byte slot.
  assign next_o = {cur_i[31:4] + 28'h0000001, 4'h0};
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the bulk pointer and done head block.
`timescale 1ns/1ns
module tb_top;
  reg clk_sys_i = 1'b0;
  reg arst_n_i = 1'b0;
  reg [7:0] ad = 8'h00;
  reg [31:0] wd = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg srv = 1'b0;
  reg lend = 1'b0;
  reg tdd = 1'b0;
  reg [31:0] tda = 32'h0;
  reg [31:0] q;
  wire [31:0] rdata, nxt, laddr, ldata, cdata, cur;
  wire lwe, cwe, run;
  integer err_total = 0;
  integer total_checks = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  blpt_top blpt_top_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(ad),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ed_served_i(srv),
    .ed_next_i(nxt), .list_end_i(lend), .td_done_i(tdd), .td_addr_i(tda), .td_link_we_o(lwe),
    .td_link_addr_o(laddr), .td_link_data_o(ldata), .comm_we_o(cwe), .comm_data_o(cdata),
    .bulk_cur_o(cur), .bulk_run_o(run));
  blpt_mem_model blpt_mem_model_inst (.cur_i(cur), .next_o(nxt));
  task close_out;
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [127:0] nm, input [31:0] seen, input [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus cycle; read data are taken one cycle after the strobe and hold until the next read.
  task bus(input w, input [7:0] a, input [31:0] d);
    @(posedge clk_sys_i);
    {ad, wd, wr, rd} <= {a, d, w, !w};
    @(posedge clk_sys_i);
    {wr, rd} <= 2'b00;
    #1 q = rdata;
  endtask
  task ev(input s, input l);
    @(posedge clk_sys_i);
    {srv, lend} <= {s, l};
    @(posedge clk_sys_i);
    {srv, lend} <= 2'b00;
    #1;
  endtask
  // Wait for the next write-back pulse, bounded beyond one default period. It always
  // steps one cycle first, so a pulse that was already seen is not taken twice.
  task wcomm;
    integer i;
    @(posedge clk_sys_i) #1;
    for (i = 0; i < 300 && cwe !== 1'b1; i = i + 1)
      @(posedge clk_sys_i) #1;
    chk("comm_we", cwe, 1'b1);
  endtask
  task t_cur;
    bus(0, 8'h2C, 0);
    chk("cur_rst", q, 32'h0);
    bus(0, 8'hFC, 0);
    chk("unmapped", q, 32'h0);
    bus(1, 8'h40, 32'h4);
    bus(1, 8'h2C, 32'h100);
    chk("cur_wr", cur, 32'h100);
    ev(1, 0);
    chk("advance", cur, 32'h110);
    ev(0, 1);
    chk("end_nofill", cur, 32'h110);
    bus(1, 8'h28, 32'hABC0);
    bus(1, 8'h08, 32'h2);
    ev(0, 1);
    chk("reload", cur, 32'hABC0);
    bus(0, 8'h08, 0);
    chk("fill_clr", q & 32'h2, 32'h0);
    bus(1, 8'h04, 32'h20);
    chk("run", run, 1'b1);
    bus(1, 8'h2C, 32'h500);
    chk("refused", cur, 32'hABC0);
    ev(1, 0);
    bus(0, 8'h2C, 0);
    chk("live", q, 32'hABD0);
    bus(1, 8'h04, 0);
  endtask
  task t_done;
    wcomm();
    @(posedge clk_sys_i);
    {tdd, tda} <= {1'b1, 32'h1000};
    @(posedge clk_sys_i);
    tda <= 32'h2008;
    @(posedge clk_sys_i);
    tdd <= 1'b0;
    #1 chk("link_data", ldata, 32'h1000);
    chk("link_addr", laddr, 32'h2000);
    chk("link_we", lwe, 1'b1);
    wcomm();
    chk("comm_head", cdata, 32'h2000);
    wcomm();
    chk("comm_zero", cdata, 32'h0);
    bus(0, 8'h30, 0);
    chk("head_reg", q, 32'h0);
  endtask
  // Tests need under three hundred cycles; far beyond that means a hang.
  initial
  begin
    #20000 err_total = err_total + 1;
    close_out();
  end
  initial
  begin
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_cur();
    t_done();
    close_out();
  end
endmodule
